// *** hdl/bcx_pkg.sv ***
// Overview of operation
// [RULE_01] call pushes program counter plus one onto the return stack first
// [RULE_02] call loads its 8-bit literal into program counter bits 7..0
// [RULE_03] call copies status bits 6..5 to counter bits 10..9, clears bit 8
// [RULE_04] call takes two cycles and changes no status flag
// [RULE_05] watchdog clear resets the watchdog counter to zero
// [RULE_06] watchdog clear resets prescaler only when assigned to the watchdog
// [RULE_07] watchdog clear sets timeout and powerdown flags, nothing else
// [RULE_08] file clear writes zero to the register and sets the zero flag
// [RULE_09] destination bit 0 selects accumulator, 1 selects the register
// [RULE_10] invert produces bitwise complement, updates only the zero flag
// [RULE_11] decrement produces value minus one modulo 256, updates only zero
// [RULE_12] increment produces value plus one, updates only the zero flag
// [RULE_13] decrement-skip delivers value minus one and leaves flags unchanged
// [RULE_14] decrement-skip with zero result discards next instruction, two cycles
package bcx_pkg;
  // ----------------------------------------
  // constants
  // ----------------------------------------
  localparam int PC_W = 11;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 5;
  localparam logic [7:0] DATA_ZERO = 8'h00;
  localparam logic [7:0] DATA_ONE = 8'h01;
  localparam logic [10:0] PC_ONE = 11'h001;
  localparam logic [10:0] PC_TWO = 11'h002;
  localparam int ST_ZERO_BIT = 2;
  localparam int ST_PD_BIT = 3;
  localparam int ST_TO_BIT = 4;
  localparam int ST_PAGE_LO = 5;
  localparam int ST_PAGE_HI = 6;
  localparam logic [7:0] STATUS_RESET = 8'h18;
  localparam logic [10:0] PC_RESET = 11'h000;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [2:0] {
    OP_NONE, OP_CALL, OP_WATCHDOG_CLEAR, OP_FILE_CLEAR,
    OP_FILE_INVERT, OP_FILE_DECREMENT, OP_FILE_INCREMENT, OP_DECREMENT_SKIP_ZERO
  } bcx_op_e;

  typedef struct packed {
    bcx_op_e op;
    logic [7:0] literal;
    logic [4:0] addr;
    logic dest;
  } bcx_instr_s;
endpackage : bcx_pkg

// *** hdl/bcx_core.sv ***
`timescale 1ns/1ns
module bcx_core (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  input wire logic instr_valid_in,
  input wire bcx_pkg::bcx_instr_s instr_in,
  input wire logic [7:0] file_rdata_in,
  input wire logic prescaler_to_watchdog_in,
  output logic [4:0] file_addr_out,
  output logic [7:0] file_wdata_out,
  output logic file_we_out,
  output logic [7:0] accum_out,
  output logic [7:0] status_out,
  output logic [10:0] program_counter_out,
  output logic [10:0] stack_push_data_out,
  output logic stack_push_out,
  output logic watchdog_clear_out,
  output logic prescaler_clear_out,
  output logic busy_out
);
  import bcx_pkg::*;

  typedef enum logic {S_EXEC, S_SECOND} bcx_state_e;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  bcx_state_e state_q;
  logic [7:0] accum_q, status_q;
  logic [10:0] pc_q;
  wire exec = clk_en_in && instr_valid_in && state_q == S_EXEC;
  wire bcx_op_e op = instr_in.op;
  wire [7:0] inv_res = ~file_rdata_in; // RULE_10
  wire [7:0] dec_res = file_rdata_in - DATA_ONE; // RULE_11 RULE_13
  wire [7:0] inc_res = file_rdata_in + DATA_ONE; // RULE_12
  wire is_arith = op == OP_FILE_INVERT || op == OP_FILE_DECREMENT ||
                  op == OP_FILE_INCREMENT || op == OP_DECREMENT_SKIP_ZERO;
  wire [7:0] result = (op == OP_FILE_INVERT) ? inv_res :
                      (op == OP_FILE_INCREMENT) ? inc_res : dec_res;
  wire to_file = op == OP_FILE_CLEAR || (is_arith && instr_in.dest); // RULE_09 RULE_08
  wire to_accum = is_arith && !instr_in.dest; // RULE_09
  wire upd_zero = op == OP_FILE_INVERT || op == OP_FILE_DECREMENT || op == OP_FILE_INCREMENT;
  wire skip = op == OP_DECREMENT_SKIP_ZERO && dec_res == DATA_ZERO; // RULE_14
  wire [10:0] pc_next = pc_q + PC_ONE;
  wire [10:0] call_target = {status_q[ST_PAGE_HI:ST_PAGE_LO], 1'b0, instr_in.literal}; // RULE_02 RULE_03

  logic [7:0] status_d;
  always_comb begin
    status_d = status_q;
    if (op == OP_FILE_CLEAR) begin
      status_d[ST_ZERO_BIT] = 1'b1; // RULE_08
    end else if (upd_zero) begin
      status_d[ST_ZERO_BIT] = (result == DATA_ZERO); // RULE_10 RULE_11 RULE_12
    end else if (op == OP_WATCHDOG_CLEAR) begin
      status_d[ST_TO_BIT] = 1'b1; // RULE_07
      status_d[ST_PD_BIT] = 1'b1; // RULE_07
    end
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  // a call or a taken skip owns the next cycle; whatever is offered then is dropped
  wire enter_second = exec && (op == OP_CALL || skip); // RULE_04 RULE_14
  wire status_we = exec && op != OP_CALL && op != OP_DECREMENT_SKIP_ZERO; // RULE_04 RULE_13
  wire presc_clear = exec && op == OP_WATCHDOG_CLEAR && prescaler_to_watchdog_in; // RULE_06
  wire [10:0] pc_skip = pc_q + PC_TWO; // RULE_14
  wire [10:0] pc_d = (op == OP_CALL) ? call_target : // RULE_02 RULE_03
                     skip ? pc_skip : pc_next; // RULE_14

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      state_q <= S_EXEC;
      busy_out <= 1'h0;
    end else if (clk_en_in) begin
      if (state_q == S_SECOND) begin
        state_q <= S_EXEC;
        busy_out <= 1'h0;
      end else if (enter_second) begin
        state_q <= S_SECOND; // RULE_04 RULE_14
        busy_out <= 1'h1;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      pc_q <= PC_RESET;
    end else if (exec) begin
      pc_q <= pc_d; // RULE_02 RULE_03 RULE_14
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      accum_q <= DATA_ZERO;
      status_q <= STATUS_RESET;
    end else begin
      if (exec && to_accum) accum_q <= result; // RULE_09
      if (status_we) status_q <= status_d; // RULE_04 RULE_13
    end
  end

  // the write port shows the last address and data until the next instruction
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      file_addr_out <= '0;
      file_wdata_out <= DATA_ZERO;
      file_we_out <= 1'h0;
    end else if (clk_en_in) begin
      file_we_out <= exec && to_file; // RULE_08 RULE_09
      if (exec) begin
        file_addr_out <= instr_in.addr;
        file_wdata_out <= (op == OP_FILE_CLEAR) ? DATA_ZERO : result; // RULE_08
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      stack_push_data_out <= PC_RESET;
      stack_push_out <= 1'h0;
      watchdog_clear_out <= 1'h0;
      prescaler_clear_out <= 1'h0;
    end else if (clk_en_in) begin
      stack_push_out <= exec && op == OP_CALL; // RULE_01
      watchdog_clear_out <= exec && op == OP_WATCHDOG_CLEAR; // RULE_05
      prescaler_clear_out <= presc_clear; // RULE_06
      if (exec && op == OP_CALL) stack_push_data_out <= pc_next; // RULE_01
    end
  end

  assign accum_out = accum_q;
  assign status_out = status_q;
  assign program_counter_out = pc_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);

  // ----------------------------------------
  // call and watchdog clear
  // ----------------------------------------
  a_call_push: assert property (exec && op == OP_CALL |=> // RULE_01
    stack_push_out && stack_push_data_out == $past(pc_q) + PC_ONE)
    else $error("call push wrong");
  a_call_target: assert property (exec && op == OP_CALL |=> // RULE_02
    program_counter_out[DATA_W-1:0] == $past(instr_in.literal))
    else $error("call low bits wrong");
  a_call_page: assert property (exec && op == OP_CALL |=> // RULE_03
    program_counter_out[PC_W-1:PC_W-2] == $past(status_q[ST_PAGE_HI:ST_PAGE_LO]) &&
    !program_counter_out[DATA_W])
    else $error("call page wrong");
  a_call_flags: assert property (exec && op == OP_CALL |=> // RULE_04
    busy_out && $stable(status_out))
    else $error("call changed flags");
  a_push_pulse: assert property (stack_push_out && clk_en_in |=> // RULE_01
    !stack_push_out)
    else $error("push pulse too long");
  a_wdt_clear: assert property (exec && op == OP_WATCHDOG_CLEAR |=> // RULE_05 RULE_07
    watchdog_clear_out && status_out[ST_TO_BIT] && status_out[ST_PD_BIT])
    else $error("watchdog clear wrong");
  a_presc_gate: assert property (exec && op == OP_WATCHDOG_CLEAR |=> // RULE_06
    prescaler_clear_out == $past(prescaler_to_watchdog_in))
    else $error("prescaler clear wrong");
  a_presc_only: assert property (prescaler_clear_out |-> // RULE_06
    watchdog_clear_out)
    else $error("prescaler cleared alone");
  a_wdt_flags: assert property (exec && op == OP_WATCHDOG_CLEAR |=> // RULE_07
    status_out[ST_ZERO_BIT:0] == $past(status_q[ST_ZERO_BIT:0]) &&
    status_out[DATA_W-1:ST_PAGE_LO] == $past(status_q[DATA_W-1:ST_PAGE_LO]))
    else $error("watchdog touched flags");

  // ----------------------------------------
  // file operations
  // ----------------------------------------
  a_fclr_zero: assert property (exec && op == OP_FILE_CLEAR |=> // RULE_08
    file_we_out && file_wdata_out == DATA_ZERO && status_out[ST_ZERO_BIT])
    else $error("file clear wrong");
  a_file_addr: assert property (exec && to_file |=> // RULE_08 RULE_09
    file_addr_out == $past(instr_in.addr))
    else $error("write address wrong");
  a_dest_sel: assert property (exec && is_arith && !instr_in.dest |=> // RULE_09
    !file_we_out && accum_out == $past(result))
    else $error("destination wrong");
  a_accum_keep: assert property (exec && is_arith && instr_in.dest |=> // RULE_09
    file_we_out && $stable(accum_out))
    else $error("accumulator touched");
  a_inc_zero: assert property (exec && op == OP_FILE_INCREMENT |=> // RULE_12
    status_out[ST_ZERO_BIT] == ($past(file_rdata_in) == 8'hff))
    else $error("increment zero wrong");
  a_inv_zero: assert property (exec && op == OP_FILE_INVERT |=> // RULE_10
    status_out[ST_ZERO_BIT] == ($past(file_rdata_in) == 8'hff))
    else $error("invert zero wrong");
  a_dec_zero: assert property (exec && op == OP_FILE_DECREMENT |=> // RULE_11
    status_out[ST_ZERO_BIT] == ($past(file_rdata_in) == DATA_ONE))
    else $error("decrement zero wrong");
  a_dsz_flags: assert property (exec && op == OP_DECREMENT_SKIP_ZERO |=> // RULE_13
    $stable(status_out))
    else $error("skip changed flags");
  a_dsz_result: assert property (exec && op == OP_DECREMENT_SKIP_ZERO && instr_in.dest |=> // RULE_13
    file_we_out && file_wdata_out == $past(file_rdata_in) - DATA_ONE)
    else $error("skip result wrong");
  a_dsz_skip: assert property (exec && op == OP_DECREMENT_SKIP_ZERO |=> // RULE_14
    busy_out == ($past(file_rdata_in) == DATA_ONE))
    else $error("skip timing wrong");
  a_skip_pc: assert property (exec && op == OP_DECREMENT_SKIP_ZERO |=> // RULE_14
    program_counter_out == $past(pc_q) + ($past(file_rdata_in) == DATA_ONE ? PC_TWO : PC_ONE))
    else $error("skip counter wrong");

  // ----------------------------------------
  // sequencing
  // ----------------------------------------
  a_busy_refuse: assert property (busy_out && clk_en_in |=> // RULE_04 RULE_14
    !busy_out && !file_we_out && !stack_push_out && !watchdog_clear_out &&
    $stable(program_counter_out) && $stable(status_out) && $stable(accum_out))
    else $error("busy cycle not idle");
  a_freeze_hold: assert property (!clk_en_in |=>
    $stable(program_counter_out) && $stable(status_out) && $stable(accum_out) &&
    $stable(busy_out) && $stable(file_we_out) && $stable(stack_push_out))
    else $error("state moved while frozen");

  // ----------------------------------------
  // coverage
  // ----------------------------------------
  c_call: cover property (exec && op == OP_CALL);
  c_skip: cover property (exec && skip);
  c_presc: cover property (exec && presc_clear);
  c_refused: cover property (busy_out && clk_en_in && instr_valid_in);
  c_frozen: cover property (!clk_en_in && instr_valid_in);
endmodule : bcx_core

// *** tb/bcx_core_tb_top.sv ***
`timescale 1ns/1ns
module bcx_core_tb_top;
  import bcx_pkg::*;
  logic mclk_in = 1'b0;
  logic reset_in = 1'b1;
  logic clk_en_in = 1'b1;
  logic instr_valid_in = 1'b0;
  bcx_instr_s instr_in = '0;
  logic [7:0] file_rdata_in = 8'h00;
  logic prescaler_to_watchdog_in = 1'b0;
  logic [4:0] file_addr_out;
  logic [7:0] file_wdata_out, accum_out, status_out, st_old, acc_old;
  logic [10:0] program_counter_out, stack_push_data_out, pc_old;
  logic file_we_out, stack_push_out, watchdog_clear_out, prescaler_clear_out, busy_out;
  int n_errors = 0;
  int comparisons = 0;
  initial forever #20 mclk_in = ~mclk_in;
  bcx_core u_dut (.mclk_in(mclk_in), .reset_in(reset_in), .clk_en_in(clk_en_in),
    .instr_valid_in(instr_valid_in), .instr_in(instr_in), .file_rdata_in(file_rdata_in),
    .prescaler_to_watchdog_in(prescaler_to_watchdog_in), .file_addr_out(file_addr_out),
    .file_wdata_out(file_wdata_out), .file_we_out(file_we_out), .accum_out(accum_out),
    .status_out(status_out), .program_counter_out(program_counter_out),
    .stack_push_data_out(stack_push_data_out), .stack_push_out(stack_push_out),
    .watchdog_clear_out(watchdog_clear_out), .prescaler_clear_out(prescaler_clear_out),
    .busy_out(busy_out));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input logic [10:0] seen, input logic [10:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run();
    if (n_errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  // one instruction, outputs sampled in the cycle after it is taken
  task automatic issue(input bcx_op_e op, input logic [7:0] lit, input logic [4:0] addr,
                       input logic dest, input logic [7:0] rd);
    pc_old = program_counter_out;
    st_old = status_out;
    acc_old = accum_out;
    @(posedge mclk_in);
    instr_in <= '{op, lit, addr, dest};
    file_rdata_in <= rd;
    instr_valid_in <= 1'b1;
    @(posedge mclk_in);
    instr_valid_in <= 1'b0;
    #1;
  endtask : issue
  task automatic idle_busy_check();
    @(posedge mclk_in);
    #1;
    check(busy_out, 1'b0);
    check(stack_push_out, 1'h0);
  endtask : idle_busy_check
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic do_call(input logic [7:0] lit);
    issue(OP_CALL, lit, 5'h00, 1'b0, 8'h00);
    check(stack_push_out, 1'b1);
    check(stack_push_data_out, pc_old + 11'h001);
    check(program_counter_out, {st_old[ST_PAGE_HI:ST_PAGE_LO], 1'h0, lit});
    check(status_out, st_old);
    check(busy_out, 1'b1);
    idle_busy_check();
  endtask : do_call
  task automatic do_file(input bcx_op_e op, input logic [7:0] rd, input logic dest,
                         input logic [7:0] exp);
    issue(op, 8'h00, 5'h1f, dest, rd);
    check(file_we_out, dest);
    if (dest) check(file_wdata_out, exp);
    if (dest) check(file_addr_out, 5'h1f);
    if (!dest) check(accum_out, exp);
    if (dest) check(accum_out, acc_old);
    check(status_out, (st_old & 8'hfb) | {5'h00, exp == 8'h00, 2'h0});
  endtask : do_file
  task automatic do_skip(input logic [7:0] rd, input logic dest, input logic taken);
    issue(OP_DECREMENT_SKIP_ZERO, 8'h00, 5'h03, dest, rd);
    check(dest ? file_wdata_out : accum_out, 8'(rd - 8'h01));
    check(file_we_out, dest);
    if (dest) check(accum_out, acc_old);
    check(status_out, st_old);
    check(program_counter_out, pc_old + (taken ? 11'h002 : 11'h001));
    check(busy_out, taken);
    idle_busy_check();
  endtask : do_skip
  // an increment offered while the clock enable is low waits, then runs
  task automatic do_freeze();
    pc_old = program_counter_out;
    st_old = status_out;
    acc_old = accum_out;
    @(posedge mclk_in);
    clk_en_in <= 1'h0;
    instr_in <= '{OP_FILE_INCREMENT, 8'h00, 5'h02, 1'h0};
    file_rdata_in <= 8'hff;
    instr_valid_in <= 1'h1;
    repeat (2) @(posedge mclk_in);
    clk_en_in <= 1'h1;
    #1;
    check(program_counter_out, pc_old);
    check(status_out, st_old);
    check(accum_out, acc_old);
    @(posedge mclk_in);
    instr_valid_in <= 1'h0;
    #1;
    check(accum_out, 8'h00);
    check(status_out, st_old | 8'h04);
    check(program_counter_out, pc_old + 11'h001);
  endtask : do_freeze
  // a file clear offered in the second cycle of a call is dropped
  task automatic do_refused();
    pc_old = program_counter_out;
    st_old = status_out;
    @(posedge mclk_in);
    instr_in <= '{OP_CALL, 8'h33, 5'h00, 1'h0};
    instr_valid_in <= 1'h1;
    @(posedge mclk_in);
    instr_in <= '{OP_FILE_CLEAR, 8'h00, 5'h07, 1'h1};
    @(posedge mclk_in);
    instr_valid_in <= 1'h0;
    #1;
    check(file_we_out, 1'h0);
    check(program_counter_out, {st_old[ST_PAGE_HI:ST_PAGE_LO], 1'h0, 8'h33});
    check(status_out, st_old);
    check(busy_out, 1'h0);
  endtask : do_refused
  initial begin
    repeat (4) @(posedge mclk_in);
    reset_in <= 1'b0;
    #1;
    check(status_out, STATUS_RESET);
    check(program_counter_out, PC_RESET);
    do_call(8'hff);
    do_skip(8'h01, 1'b1, 1'b1);
    do_call(8'h5a);
    for (int p = 0; p < 2; p++) begin
      @(posedge mclk_in);
      prescaler_to_watchdog_in <= p[0];
      issue(OP_WATCHDOG_CLEAR, 8'h00, 5'h00, 1'b0, 8'h00);
      check(watchdog_clear_out, 1'b1);
      check(prescaler_clear_out, p[0]);
      check(status_out, st_old | 8'h18);
    end
    do_file(OP_FILE_CLEAR, 8'h5a, 1'b1, 8'h00);
    for (int d = 0; d < 2; d++) begin
      do_file(OP_FILE_INVERT, 8'h3c, d[0], 8'hc3);
      do_file(OP_FILE_INVERT, 8'hff, d[0], 8'h00);
      do_file(OP_FILE_INCREMENT, 8'hff, d[0], 8'h00);
      do_file(OP_FILE_DECREMENT, 8'h00, d[0], 8'hff);
    end
    do_skip(8'h01, 1'b0, 1'b1);
    do_file(OP_FILE_CLEAR, 8'h11, 1'b1, 8'h00);
    do_skip(8'h02, 1'b0, 1'b0);
    do_freeze();
    do_refused();
    complete_run();
  end
  initial begin
    repeat (5000) @(posedge mclk_in);
    n_errors++;
    complete_run();
  end
endmodule : bcx_core_tb_top
